// ===== common/dac_ctl_map.svh
`ifndef DAC_CTL_MAP_SVH
`define DAC_CTL_MAP_SVH

// Command nibble codes of the first data byte
`define CMD_LOAD_BOTH   4'hc
`define CMD_LOAD_IN     4'hd
`define CMD_LOAD_PRIOR  4'he
`define CMD_XFER        4'hf
`define CMD_RD_PFX      2'h2
`define CMD_PD_PFX      2'h1

// Power-down field position inside the 12-bit code word
`define PD_FIELD_HI     11
`define PD_FIELD_LO     10

// Reset values
`define PD_RESET        2'h3
`define DAC_RESET       12'h000
`define ANA_RESET       4'h1

// Address values
`define ADDR_PRESET     6'h08
`define GC_ADDR         7'h00

// Upper nibble sent ahead of the code in the first read byte
`define RD_HI_PAD       4'h0

// Bit counter positions inside one nine-clock byte slot
`define LAST_BIT        4'h7
`define ACK_SLOT        4'h8

`endif

// ===== common/dac_ctl_pkg.sv
`default_nettype none
package dac_ctl_pkg;

  typedef logic [11:0] dac_code_t;

  // Link sequencer, gray along idle-address-write path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_WR_HI = 3'h3,
    ST_WR_LO = 3'h2,
    ST_RD_HI = 3'h6,
    ST_RD_LO = 3'h7
  } link_state_e;

  // Completed write: command nibble and code bits
  typedef struct packed {
    logic [3:0] cmd;
    dac_code_t  code;
  } wr_word_s;

  // Controls of the analog output stage
  typedef struct packed {
    logic buf_en;
    logic string_en;
    logic term_1k;
    logic term_100k;
  } analog_ctl_s;

endpackage
`default_nettype wire

// ===== rtl/i2c_dac_slave_control.sv
// Behaviour
// RULE_01: DAC code is plain unsigned binary, 0 to 4095.
// RULE_02: Writes go to DAC register (output moves) or input register only.
// RULE_03: Reset zeroes both registers, powers down with 100k to ground.
// RULE_04: Master must send a wake-up command before expecting output.
// RULE_05: Power bits 00 up, 01 float, 10 1k ground, 11 100k ground.
// RULE_06: Any power-down disables buffer and string, keeps both registers.
// RULE_07: Slave only; master makes SCL and starts transfers, up to 400 kHz.
// RULE_08: Bytes are eight bits plus acknowledge clock, framed START to STOP.
// RULE_09: One bit per SCL cycle; SDA change while SCL high is control.
// RULE_10: START is SDA falling, STOP is SDA rising, both with SCL high.
// RULE_11: After STOP or wrong address, ignore SCL until next START.
// RULE_12: STOP accepted anywhere except in the same high pulse as START.
// RULE_13: Back-to-back writes allowed; reads need repeated START.
// RULE_14: Acknowledge matching address and each data byte by pulling SDA.
// RULE_15: When sending, master acknowledges; master ends read with NACK.
// RULE_16: Master should retry later when a transfer is not acknowledged.
// RULE_17: Address compared bit by bit, dropping out on first mismatch.
// RULE_18: Address byte LSB is direction: 0 write, 1 read.
// RULE_19: Address bits six to one preset; bit zero from select pin.
// RULE_20: Write bytes carry four-bit command then twelve code bits.
// RULE_21: Registers update on SCL fall ending the last byte's acknowledge.
// RULE_22: Aborted write leaves registers unchanged.
// RULE_23: Commands C, D, E, F load paths; 10xx read; 01xx power bits.
// RULE_24: Read returns DAC register as two bytes with master ACK between.
// RULE_25: General call ignored; seven-bit addressing only.
// RULE_26: Data goes MSB byte and MSB bit first, command in first byte.
`include "dac_ctl_map.svh"
`default_nettype none
module i2c_dac_slave_control #(
  parameter logic [5:0] ADDR_HI = `ADDR_PRESET
) (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Two-wire bus, SCL clocks the link logic
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Address select strap
  input  wire logic        addr_lsb,
  // Analog core controls
  output logic [11:0]      dac_code_bits,
  output logic             buf_en,
  output logic             string_en,
  output logic             term_1k,
  output logic             term_100k,
  // Power-down state
  output logic             pwrdn_sel_hi,
  output logic             pwrdn_sel_lo
);

  // Expected seven-bit address from preset and strap
  function automatic logic [6:0] own_addr(input logic lsb);
    own_addr = {ADDR_HI, lsb};
  endfunction

  // Output stage settings for a power-down field
  function automatic dac_ctl_pkg::analog_ctl_s pd_decode(
    input logic [1:0] pd);
    pd_decode = '0;
    case (pd)
      2'h0: begin
        pd_decode.buf_en    = 1'b1;
        pd_decode.string_en = 1'b1;
      end
      2'h1: pd_decode.term_1k = 1'b0;
      2'h2: pd_decode.term_1k = 1'b1;
      default: pd_decode.term_100k = 1'b1;
    endcase
  endfunction

  logic                     rst_meta_q;
  logic                     rst_n_q;
  logic                     lsb_meta_q;
  logic                     lsb_q;
  logic                     start_tgl_q;
  logic                     stop_tgl_q;
  logic                     start_seen_q;
  logic                     stop_seen_q;
  logic                     start_new;
  logic                     stop_new;
  dac_ctl_pkg::link_state_e state_q;
  logic [3:0]               cnt_q;
  logic                     dir_q;
  logic                     oe_q;
  logic                     out_q;
  logic [7:0]               tx_q;
  logic [7:0]               hi_q;
  logic [7:0]               rx_q;
  logic                     mack_q;
  logic [6:0]               addr_exp;
  logic [7:0]               rd_first;
  dac_ctl_pkg::wr_word_s    wr_word_q;
  logic                     wr_tgl_q;
  logic                     wr_meta_q;
  logic                     wr_sync_q;
  logic                     wr_seen_q;
  logic                     wr_take;
  dac_ctl_pkg::dac_code_t   in_q;
  dac_ctl_pkg::dac_code_t   dac_q;
  logic [1:0]               pd_q;
  dac_ctl_pkg::analog_ctl_s ana_q;

  // Reset released through two flops; also resets the bus domains
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Strap synchroniser; the SCL side treats lsb_q as static
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lsb_meta_q <= 1'b0;
      lsb_q      <= 1'b0;
    end else begin
      lsb_meta_q <= addr_lsb;
      lsb_q      <= lsb_meta_q;
    end
  end

  // START marker: SDA falls while SCL high
  always_ff @(negedge sda_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      start_tgl_q <= 1'b0;
    end else if (scl) begin
      start_tgl_q <= ~start_tgl_q; // RULE_10
    end
  end

  // STOP marker: SDA rises while SCL high
  always_ff @(posedge sda_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stop_tgl_q <= 1'b0;
    end else if (scl) begin
      stop_tgl_q <= ~stop_tgl_q; // RULE_10
    end
  end

  // Bus hold times keep the markers settled before the next SCL fall
  assign start_new = start_tgl_q != start_seen_q;
  assign stop_new  = stop_tgl_q != stop_seen_q;

  // Own address for the bit compare, and the first read byte
  assign addr_exp = own_addr(lsb_q); // RULE_19
  assign rd_first = {`RD_HI_PAD, dac_q[11:8]}; // RULE_26

  // Sample SDA on SCL rise; idle bus is not looked at
  always_ff @(posedge scl or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_q   <= 8'h00;
      mack_q <= 1'b1;
    end else if (state_q != dac_ctl_pkg::ST_IDLE) begin // RULE_11
      if (cnt_q != `ACK_SLOT) begin
        rx_q <= {rx_q[6:0], sda_in}; // RULE_09
      end else begin
        mack_q <= sda_in; // RULE_15
      end
    end
  end

  // Byte sequencer on SCL fall: framing, acknowledge and SDA drive
  always_ff @(negedge scl or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q      <= dac_ctl_pkg::ST_IDLE;
      cnt_q        <= 4'h0;
      dir_q        <= 1'b0;
      oe_q         <= 1'b0;
      out_q        <= 1'b0;
      tx_q         <= 8'h00;
      hi_q         <= 8'h00;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
      wr_word_q    <= '0;
      wr_tgl_q     <= 1'b0;
    end else if (start_new) begin
      // A STOP in the same high pulse is swallowed by the START
      state_q      <= dac_ctl_pkg::ST_ADDR; // RULE_13
      cnt_q        <= 4'h0;
      oe_q         <= 1'b0;
      start_seen_q <= start_tgl_q;
      stop_seen_q  <= stop_tgl_q; // RULE_12
    end else if (stop_new) begin
      state_q     <= dac_ctl_pkg::ST_IDLE; // RULE_12
      oe_q        <= 1'b0;
      stop_seen_q <= stop_tgl_q;
    end else if (state_q != dac_ctl_pkg::ST_IDLE) begin // RULE_11
      if (cnt_q != `ACK_SLOT) begin
        cnt_q <= cnt_q + 4'h1; // RULE_08
        case (state_q)
          dac_ctl_pkg::ST_ADDR: begin
            if (cnt_q == `LAST_BIT) begin
              if (rx_q[7:1] != `GC_ADDR) begin // RULE_25
                dir_q <= rx_q[0]; // RULE_18
                oe_q  <= 1'b1; // RULE_14
              end else begin
                state_q <= dac_ctl_pkg::ST_IDLE;
              end
            end else if (rx_q[0] != addr_exp[3'h6 - cnt_q[2:0]]) begin
              state_q <= dac_ctl_pkg::ST_IDLE; // RULE_17 RULE_19
            end
          end
          dac_ctl_pkg::ST_WR_HI,
          dac_ctl_pkg::ST_WR_LO: begin
            if (cnt_q == `LAST_BIT) begin
              oe_q <= 1'b1; // RULE_14
              if (state_q == dac_ctl_pkg::ST_WR_HI) begin
                hi_q <= rx_q; // RULE_20
              end
            end
          end
          dac_ctl_pkg::ST_RD_HI,
          dac_ctl_pkg::ST_RD_LO: begin
            // Let go of SDA for the master's acknowledge
            oe_q <= (cnt_q == `LAST_BIT) ? 1'b0 : ~tx_q[7]; // RULE_15
            tx_q <= {tx_q[6:0], 1'b0}; // RULE_26
          end
          default: state_q <= dac_ctl_pkg::ST_IDLE;
        endcase
      end else begin
        cnt_q <= 4'h0;
        oe_q  <= 1'b0;
        case (state_q)
          dac_ctl_pkg::ST_ADDR: begin
            if (dir_q) begin
              // DAC register changes only after a crossed write, so it
              // is quiet by the time a read byte is loaded
              state_q <= dac_ctl_pkg::ST_RD_HI; // RULE_24
              tx_q    <= {rd_first[6:0], 1'b0};
              oe_q    <= ~rd_first[7]; // RULE_26
            end else begin
              state_q <= dac_ctl_pkg::ST_WR_HI;
            end
          end
          dac_ctl_pkg::ST_WR_HI: state_q <= dac_ctl_pkg::ST_WR_LO;
          dac_ctl_pkg::ST_WR_LO: begin
            // Only a full pair reaches here, so aborts change nothing
            state_q        <= dac_ctl_pkg::ST_WR_HI; // RULE_13 RULE_22
            wr_word_q.cmd  <= hi_q[7:4]; // RULE_20
            wr_word_q.code <= {hi_q[3:0], rx_q}; // RULE_26
            wr_tgl_q       <= ~wr_tgl_q; // RULE_21
          end
          dac_ctl_pkg::ST_RD_HI: begin
            if (!mack_q) begin
              state_q <= dac_ctl_pkg::ST_RD_LO; // RULE_24
              tx_q    <= {dac_q[6:0], 1'b0};
              oe_q    <= ~dac_q[7]; // RULE_26
            end else begin
              state_q <= dac_ctl_pkg::ST_IDLE; // RULE_15
            end
          end
          default: state_q <= dac_ctl_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Open drain: the pin level is only ever pulled low
  assign sda_out = out_q;
  assign sda_oe  = oe_q; // RULE_07

  // Write toggle crosses into clk; the word is held still meanwhile
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_meta_q <= 1'b0;
      wr_sync_q <= 1'b0;
      wr_seen_q <= 1'b0;
    end else begin
      wr_meta_q <= wr_tgl_q;
      wr_sync_q <= wr_meta_q;
      wr_seen_q <= wr_sync_q;
    end
  end

  assign wr_take = wr_sync_q ^ wr_seen_q;

  // Input and DAC registers by command
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      in_q  <= `DAC_RESET; // RULE_03
      dac_q <= `DAC_RESET;
    end else if (wr_take) begin
      case (wr_word_q.cmd)
        `CMD_LOAD_BOTH: begin
          in_q  <= wr_word_q.code; // RULE_02 RULE_23
          dac_q <= wr_word_q.code;
        end
        `CMD_LOAD_IN: in_q <= wr_word_q.code; // RULE_02 RULE_23
        `CMD_LOAD_PRIOR: begin
          in_q  <= wr_word_q.code; // RULE_23
          dac_q <= in_q;
        end
        `CMD_XFER: dac_q <= in_q; // RULE_23
        default: dac_q <= dac_q;
      endcase
    end
  end

  // Power-down field; code registers are left alone
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pd_q <= `PD_RESET; // RULE_03
    end else if (wr_take && wr_word_q.cmd[3:2] == `CMD_PD_PFX) begin
      pd_q <= wr_word_q.code[`PD_FIELD_HI:`PD_FIELD_LO]; // RULE_06
    end
  end

  // Analog controls registered so every output is a flop
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ana_q <= dac_ctl_pkg::analog_ctl_s'(`ANA_RESET); // RULE_03
    end else begin
      ana_q <= pd_decode(pd_q); // RULE_05 RULE_06
    end
  end

  // Code is passed on as unsigned binary for the string
  assign dac_code_bits = dac_q; // RULE_01
  assign buf_en        = ana_q.buf_en;
  assign string_en     = ana_q.string_en;
  assign term_1k       = ana_q.term_1k;
  assign term_100k     = ana_q.term_100k;
  assign pwrdn_sel_hi  = pd_q[1];
  assign pwrdn_sel_lo  = pd_q[0];

  // A byte slot ending with no bus condition pending
  sequence s_slot_end(logic [3:0] pos);
    !start_new && !stop_new && cnt_q == pos;
  endsequence

  // A completed write of one command arriving in clk
  sequence s_take(logic [3:0] c);
    wr_take && wr_word_q.cmd == c;
  endsequence

  a_ack_address: assert property ( // RULE_14
    @(negedge scl) disable iff (!rst_n_q)
    state_q == dac_ctl_pkg::ST_ADDR && rx_q[7:1] == own_addr(lsb_q)
    ##0 s_slot_end(`LAST_BIT) |=> oe_q && cnt_q == `ACK_SLOT)
    else $error("matching address not acknowledged");

  a_ack_data: assert property ( // RULE_14
    @(negedge scl) disable iff (!rst_n_q)
    (state_q == dac_ctl_pkg::ST_WR_HI || state_q == dac_ctl_pkg::ST_WR_LO)
    ##0 s_slot_end(`LAST_BIT) |=> oe_q ##1 !oe_q || start_new)
    else $error("data byte acknowledge wrong");

  a_addr_drop: assert property ( // RULE_17
    @(negedge scl) disable iff (!rst_n_q)
    state_q == dac_ctl_pkg::ST_ADDR && cnt_q < `LAST_BIT &&
    !start_new && !stop_new &&
    rx_q[0] != addr_exp[3'h6 - cnt_q[2:0]]
    |=> state_q == dac_ctl_pkg::ST_IDLE && !oe_q)
    else $error("address mismatch did not drop out");

  a_idle_quiet: assert property ( // RULE_11
    @(negedge scl) disable iff (!rst_n_q)
    state_q == dac_ctl_pkg::ST_IDLE && !start_new
    |=> state_q == dac_ctl_pkg::ST_IDLE && !oe_q)
    else $error("idle link reacted to SCL");

  a_tx_release: assert property ( // RULE_15
    @(negedge scl) disable iff (!rst_n_q)
    (state_q == dac_ctl_pkg::ST_RD_HI || state_q == dac_ctl_pkg::ST_RD_LO)
    ##0 s_slot_end(`LAST_BIT) |=> !oe_q)
    else $error("SDA held during master acknowledge");

  a_commit_edge: assert property ( // RULE_21
    @(negedge scl) disable iff (!rst_n_q)
    state_q == dac_ctl_pkg::ST_WR_LO ##0 s_slot_end(`ACK_SLOT)
    |=> wr_tgl_q != $past(wr_tgl_q) && state_q == dac_ctl_pkg::ST_WR_HI)
    else $error("write not committed at acknowledge fall");

  a_load_both: assert property ( // RULE_23
    @(posedge clk) disable iff (!rst_n_q)
    s_take(`CMD_LOAD_BOTH)
    |=> dac_q == $past(wr_word_q.code) && in_q == $past(wr_word_q.code))
    else $error("load-both did not load both registers");

  a_input_only: assert property ( // RULE_02
    @(posedge clk) disable iff (!rst_n_q)
    s_take(`CMD_LOAD_IN)
    |=> dac_q == $past(dac_q) && in_q == $past(wr_word_q.code))
    else $error("input-only load moved the output");

  a_prior_data: assert property ( // RULE_23
    @(posedge clk) disable iff (!rst_n_q)
    s_take(`CMD_LOAD_PRIOR) |=> dac_q == $past(in_q))
    else $error("output not updated to prior input data");

  a_transfer: assert property ( // RULE_23
    @(posedge clk) disable iff (!rst_n_q)
    s_take(`CMD_XFER) |=> dac_q == $past(in_q) && $stable(in_q))
    else $error("transfer command wrong");

  a_pd_keeps: assert property ( // RULE_06
    @(posedge clk) disable iff (!rst_n_q)
    wr_take && wr_word_q.cmd[3:2] == `CMD_PD_PFX
    |=> $stable(dac_q) && $stable(in_q) ##1 ana_q == pd_decode(pd_q))
    else $error("power-down write disturbed data");

  a_buffer_off: assert property ( // RULE_05
    @(posedge clk) disable iff (!rst_n_q)
    pd_q != 2'h0 |=> !ana_q.buf_en && !ana_q.string_en)
    else $error("buffer enabled in power-down");

  a_reset_state: assert property ( // RULE_03
    @(posedge clk) disable iff (!rst_n_q)
    $rose(rst_n_q) |-> pd_q == `PD_RESET && dac_q == `DAC_RESET &&
    ana_q.term_100k && !ana_q.buf_en)
    else $error("reset state wrong");

endmodule
`default_nettype wire

// ===== tb/dac_bus_master.sv
`default_nettype none
module dac_bus_master (
  // Resolved data wire
  input  wire logic sda_w,
  // Master drives
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus idles high and SCL stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Also serves as repeated START from mid-frame
  task automatic start();
    #12 sda_low = 1'b0;
    #12 scl = 1'b1;
    #12 sda_low = 1'b1;
    #12 scl = 1'b0;
  endtask

  // Data low first, then rise under high clock
  task automatic stop();
    #12 sda_low = 1'b1;
    #12 scl = 1'b1;
    #12 sda_low = 1'b0;
    #24;
  endtask

  // Eight bits MSB first plus the ninth clock for the slave's answer
  task automatic tx(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #12 sda_low = ~b[i];
      #12 scl = 1'b1;
      #24 scl = 1'b0;
    end
    #12 sda_low = 1'b0;
    #12 scl = 1'b1;
    #12 ack = ~sda_w;
    #12 scl = 1'b0;
  endtask

  // Receive a byte; nack high ends the read
  task automatic rx(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #12 sda_low = 1'b0;
      #12 scl = 1'b1;
      #12 b[i] = sda_w;
      #12 scl = 1'b0;
    end
    #12 sda_low = ~nack;
    #12 scl = 1'b1;
    #24 scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/i2c_dac_slave_control_tb_top.sv
`default_nettype none
module i2c_dac_slave_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [5:0] AHI = 6'h08;

  logic        clk;
  logic        arst_n;
  logic        addr_lsb;
  logic        scl;
  logic        sda_low;
  logic        sda_w;
  logic        sda_out;
  logic        sda_oe;
  logic [11:0] dac_code_bits;
  logic        buf_en;
  logic        string_en;
  logic        term_1k;
  logic        term_100k;
  logic        pwrdn_sel_hi;
  logic        pwrdn_sel_lo;
  logic [15:0] ana;
  int          n_mismatch;
  int          num_checks;
  int          cyc;

  // Open-drain wire with pull-up: low if either party pulls
  assign sda_w = ~sda_low & ~(sda_oe & ~sda_out);
  assign ana = {10'h0, pwrdn_sel_hi, pwrdn_sel_lo, buf_en, string_en,
                term_1k, term_100k};

  i2c_dac_slave_control #(.ADDR_HI(AHI)) i2c_dac_slave_control_inst (
    .clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_lsb(addr_lsb),
    .dac_code_bits(dac_code_bits), .buf_en(buf_en),
    .string_en(string_en), .term_1k(term_1k), .term_100k(term_100k),
    .pwrdn_sel_hi(pwrdn_sel_hi), .pwrdn_sel_lo(pwrdn_sel_lo)
  );

  dac_bus_master dac_bus_master_inst (
    .sda_w(sda_w), .scl(scl), .sda_low(sda_low)
  );

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  // START plus address byte, judging the slave's answer
  task automatic adr(input logic [6:0] a, input logic rw, exp);
    logic ak;
    dac_bus_master_inst.start();
    dac_bus_master_inst.tx({a, rw}, ak);
    chk({15'h0, ak}, {15'h0, exp}, "address ack");
  endtask

  // One command pair: command nibble and top code bits, then low byte
  task automatic wr(input logic [3:0] cmd, input logic [11:0] code);
    logic ak;
    dac_bus_master_inst.tx({cmd, code[11:8]}, ak);
    chk({15'h0, ak}, 16'h1, "first byte ack");
    dac_bus_master_inst.tx(code[7:0], ak);
    chk({15'h0, ak}, 16'h1, "second byte ack");
  endtask

  // Stop and let the commit cross into the system clock
  task automatic fin();
    dac_bus_master_inst.stop();
    repeat (5) @(posedge clk);
  endtask

  // Read back the DAC register over a fresh or repeated START
  task automatic rd(input logic [11:0] exp);
    logic [7:0] b1;
    logic [7:0] b2;
    adr({AHI, 1'b0}, 1'b1, 1'b1);
    dac_bus_master_inst.rx(1'b0, b1);
    dac_bus_master_inst.rx(1'b1, b2);
    chk({b1, b2}, {4'h0, exp}, "read word");
  endtask

  task automatic t_reset();
    chk({4'h0, dac_code_bits}, 16'h0, "reset code");
    chk(ana, 16'h0031, "reset power state");
    chk({15'h0, sda_oe}, 16'h0, "reset sda drive");
  endtask

  // Each power mode, ending on wake-up; code must survive them all
  task automatic t_power();
    logic [1:0]  seq [4];
    logic [3:0]  outs [4];
    seq = '{2'h1, 2'h2, 2'h3, 2'h0};
    outs = '{4'h0, 4'h2, 4'h1, 4'hc};
    adr({AHI, 1'b0}, 1'b0, 1'b1);
    wr(4'hc, 12'h5a5);
    fin();
    for (int i = 0; i < 4; i++) begin
      adr({AHI, 1'b0}, 1'b0, 1'b1);
      wr(4'h4, {seq[i], 10'h3ff});
      fin();
      chk(ana, {10'h0, seq[i], outs[i]}, "power outputs");
      chk({4'h0, dac_code_bits}, 16'h05a5, "code kept");
    end
  endtask

  // Load paths, back-to-back pairs, one repeated-START read and one fresh-START read
  task automatic t_load();
    adr({AHI, 1'b0}, 1'b0, 1'b1);
    wr(4'hc, 12'hfff);
    fin();
    chk({4'h0, dac_code_bits}, 16'h0fff, "full scale");
    adr({AHI, 1'b0}, 1'b0, 1'b1);
    wr(4'hd, 12'h123);
    fin();
    chk({4'h0, dac_code_bits}, 16'h0fff, "input only");
    adr({AHI, 1'b0}, 1'b0, 1'b1);
    wr(4'he, 12'h456);
    wr(4'h8, 12'h777);
    rd(12'h123);
    adr({AHI, 1'b0}, 1'b0, 1'b1);
    wr(4'hf, 12'h000);
    fin();
    chk({4'h0, dac_code_bits}, 16'h0456, "transfer");
    rd(12'h456);
    fin();
  endtask

  // Half a pair then STOP, and a foreign address followed by data
  task automatic t_abort();
    logic ak;
    adr({AHI, 1'b0}, 1'b0, 1'b1);
    dac_bus_master_inst.tx({4'hc, 4'h1}, ak);
    chk({15'h0, ak}, 16'h1, "half pair ack");
    fin();
    chk({4'h0, dac_code_bits}, 16'h0456, "aborted");
    adr({AHI, 1'b1}, 1'b0, 1'b0);
    dac_bus_master_inst.tx({4'hc, 4'h2}, ak);
    chk({15'h0, ak}, 16'h0, "ignored byte");
    dac_bus_master_inst.tx(8'h22, ak);
    chk({15'h0, ak}, 16'h0, "ignored low byte");
    fin();
    chk({4'h0, dac_code_bits}, 16'h0456, "foreign write");
    adr(7'h00, 1'b0, 1'b0);
    fin();
  endtask

  // Strap high moves the address to the odd one
  task automatic t_strap();
    addr_lsb <= 1'b1;
    repeat (4) @(posedge clk);
    adr({AHI, 1'b0}, 1'b0, 1'b0);
    fin();
    adr({AHI, 1'b1}, 1'b0, 1'b1);
    wr(4'hc, 12'h321);
    fin();
    chk({4'h0, dac_code_bits}, 16'h0321, "strap write");
    addr_lsb <= 1'b0;
  endtask

  // Hang guard: a full run needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("wrong value at %0t: run did not finish", $time);
      end_sim();
    end
  end

  initial begin
    arst_n = 1'b0;
    addr_lsb = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_power();
    t_load();
    t_abort();
    t_strap();
    end_sim();
  end
endmodule
`default_nettype wire
